// File: shared/spt_map.vh
// Timing constants for the flash power and operation sequencer
`ifndef SPT_MAP_VH
`define SPT_MAP_VH
// Clock period in picoseconds (125 MHz)
`define SPT_CLK_PS          8000
// Times in their printed units
`define SPT_PWRUP_US        260
`define SPT_DEEP_ENTER_US   3
`define SPT_ULTRA_ENTER_US  3
`define SPT_TERM_US         50
`define SPT_SWRST_US        260
`define SPT_ULTRA_EXIT_US   260
`define SPT_ULTRA_EXIT_LONG_US 1200
`define SPT_ULTRA_LONG_MS   400
`define SPT_DEEP_EXIT_US    35
`define SPT_PAGE_PROG_US    6500
`define SPT_PAGE_RMW_MS     82
`define SPT_BYTE_PROG_US    32
`define SPT_OTP_MS          6
`define SPT_WRSR_MS         15
`define SPT_CHIP_ERASE_S    37
// Cycle counts, 33 bits wide so a full chip erase fits
`define SPT_US2CYC(u) ((u) * (33'h0_000f_4240 / `SPT_CLK_PS))
// Operation codes on op_code
`define SPT_OP_NONE   3'h0
`define SPT_OP_PAGE   3'h1
`define SPT_OP_RMW    3'h2
`define SPT_OP_BYTE   3'h3
`define SPT_OP_OTP    3'h4
`define SPT_OP_WRSR   3'h5
`define SPT_OP_CHIP   3'h6
// Sleep and reset requests on sys_cmd
`define SPT_CMD_NONE  3'h0
`define SPT_CMD_DEEP  3'h1
`define SPT_CMD_ULTRA 3'h2
`define SPT_CMD_TERM  3'h3
`define SPT_CMD_SWRST 3'h4
`define SPT_CMD_WAKE  3'h5
`endif

// File: rtl/spt_seq.v
// Power-up, sleep and operation timing sequencer of a serial flash
`timescale 1ns/1ps
`include "spt_map.vh"
module spt_seq #(
  parameter [32:0] PWRUP_CYC  = `SPT_US2CYC(`SPT_PWRUP_US),
  parameter [32:0] DEEP_IN_CYC  = `SPT_US2CYC(`SPT_DEEP_ENTER_US),
  parameter [32:0] ULTRA_IN_CYC = `SPT_US2CYC(`SPT_ULTRA_ENTER_US),
  parameter [32:0] TERM_CYC   = `SPT_US2CYC(`SPT_TERM_US),
  parameter [32:0] SWRST_CYC  = `SPT_US2CYC(`SPT_SWRST_US),
  parameter [32:0] UEXIT_CYC  = `SPT_US2CYC(`SPT_ULTRA_EXIT_US),
  parameter [32:0] UEXIT_LONG_CYC = `SPT_US2CYC(`SPT_ULTRA_EXIT_LONG_US),
  parameter [32:0] ULONG_CYC  = `SPT_US2CYC(`SPT_ULTRA_LONG_MS * 1000),
  parameter [32:0] DEXIT_CYC  = `SPT_US2CYC(`SPT_DEEP_EXIT_US),
  parameter [32:0] PAGE_CYC   = `SPT_US2CYC(`SPT_PAGE_PROG_US),
  parameter [32:0] RMW_CYC    = `SPT_US2CYC(`SPT_PAGE_RMW_MS * 1000),
  parameter [32:0] BYTE_CYC   = `SPT_US2CYC(`SPT_BYTE_PROG_US),
  parameter [32:0] OTP_CYC    = `SPT_US2CYC(`SPT_OTP_MS * 1000),
  parameter [32:0] WRSR_CYC   = `SPT_US2CYC(`SPT_WRSR_MS * 1000),
  parameter [32:0] CHIP_CYC   = `SPT_US2CYC(`SPT_CHIP_ERASE_S * 1000000)
) (
  input  wire        ref_clk,        // System clock
  input  wire        rstn,           // Async reset, active low
  input  wire        clk_en,         // Freezes all state when low
  input  wire        por_n,          // Internal power-on reset, low active
  input  wire        hw_reset,       // Standard hardware reset sequence seen
  input  wire        cs_n,           // Chip select from host
  input  wire        sck,            // Serial clock level from host
  input  wire        so_data,        // Serial data from core
  input  wire        so_drive,       // Core wants to drive serial out
  input  wire [2:0]  sys_cmd,        // Sleep/reset request, with cmd_valid
  input  wire        cmd_valid,      // One-cycle command strobe
  input  wire [2:0]  op_code,        // Program/erase kind, with op_valid
  input  wire        op_valid,       // One-cycle operation start strobe
  output reg         so_o,           // Serial out data
  output reg         so_oe,          // Serial out enable
  output reg         spi_mode3,      // Mode chosen at select fall
  output wire        cmd_accept,     // Commands may be taken now
  output reg         busy,           // Internal operation in progress
  output reg         deep_sleep_state,            // In deep sleep
  output reg         ultra_low_power_sleep_state, // In ultra sleep
  output reg         por_done        // Power-on initialisation finished
);

  // One-hot states
  localparam [7:0] S_POR    = 8'h01; // Power-on init running
  localparam [7:0] S_IDLE   = 8'h02; // Ready
  localparam [7:0] S_ENTER  = 8'h04; // Waiting select high, then entry
  localparam [7:0] S_DEEP   = 8'h08; // Deep sleep
  localparam [7:0] S_ULTRA  = 8'h10; // Ultra sleep
  localparam [7:0] S_WAKE   = 8'h20; // Leaving sleep
  localparam [7:0] S_RECOV  = 8'h40; // Terminate/reset recovery
  localparam [7:0] S_OP     = 8'h80; // Program/erase/status write

  reg  [7:0]  state_q;      // Current state
  reg  [32:0] cnt_q;        // Down counter, wide enough for chip erase
  reg  [31:0] stay_q;       // Cycles spent in ultra sleep, saturating
  reg         to_ultra_q;   // Entry target is ultra sleep
  reg         cs_n_q;       // Select delayed for edge detect
  reg         started_q;    // Select fall seen since reset

  // Duration of a program/erase kind
  function [32:0] op_len;
    input [2:0] code;
    begin
      case (code)
        `SPT_OP_PAGE: op_len = PAGE_CYC;
        `SPT_OP_RMW:  op_len = RMW_CYC;
        `SPT_OP_BYTE: op_len = BYTE_CYC;
        `SPT_OP_OTP:  op_len = OTP_CYC;
        `SPT_OP_WRSR: op_len = WRSR_CYC;
        `SPT_OP_CHIP: op_len = CHIP_CYC;
        default:      op_len = 33'h0_0000_0001;
      endcase
    end
  endfunction

  wire cs_fall = cs_n_q & ~cs_n;          // Select falling edge
  wire cs_rise = ~cs_n_q & cs_n;          // Select rising edge
  wire cnt_end = (cnt_q == 33'h0_0000_0000); // Timer expired

  // Commands only in ready state, after power-on and a select fall
  assign cmd_accept = state_q[1] & por_n & started_q;

  // Select edge tracking and mode sampling
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cs_n_q    <= 1'b1;
      spi_mode3 <= 1'b0;
      started_q <= 1'b0;
    end else if (clk_en) begin
      cs_n_q <= cs_n;
      if (cs_fall) begin
        spi_mode3 <= sck;
        started_q <= 1'b1;
      end
      if (!por_n || state_q[0]) begin
        started_q <= 1'b0;
      end
    end
  end

  // Serial output stays high-Z until ready and selected
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      so_o  <= 1'b0;
      so_oe <= 1'b0;
    end else if (clk_en) begin
      so_o  <= so_data;
      so_oe <= so_drive & ~cs_n & cmd_accept;
    end
  end

  // Main sequencer
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= S_POR;
      cnt_q      <= 33'h0_0000_0000;
      stay_q     <= 32'h0000_0000;
      to_ultra_q <= 1'b0;
      busy       <= 1'b0;
      por_done   <= 1'b0;
      deep_sleep_state            <= 1'b0;
      ultra_low_power_sleep_state <= 1'b0;
    end else if (clk_en) begin
      if (!por_n) begin
        // Held in reset while supply is low
        state_q  <= S_POR;
        cnt_q    <= PWRUP_CYC;
        busy     <= 1'b0;
        por_done <= 1'b0;
        deep_sleep_state            <= 1'b0;
        ultra_low_power_sleep_state <= 1'b0;
      end else if (hw_reset && (state_q[0] || !por_done)) begin
        // Restart unfinished initialisation
        state_q <= S_POR;
        cnt_q   <= PWRUP_CYC;
      end else begin
        case (state_q)
          S_POR: begin
            // Count out the power-up delay
            if (cnt_end) begin
              state_q  <= S_IDLE;
              por_done <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 33'h0_0000_0001;
            end
          end
          S_IDLE: begin
            if (op_valid && started_q) begin
              state_q <= S_OP;
              busy    <= 1'b1;
              cnt_q   <= op_len(op_code);
            end else if (cmd_valid && started_q) begin
              case (sys_cmd)
                `SPT_CMD_DEEP: begin
                  state_q    <= S_ENTER;
                  to_ultra_q <= 1'b0;
                  cnt_q      <= DEEP_IN_CYC;
                end
                `SPT_CMD_ULTRA: begin
                  state_q    <= S_ENTER;
                  to_ultra_q <= 1'b1;
                  cnt_q      <= ULTRA_IN_CYC;
                end
                `SPT_CMD_TERM: begin
                  state_q <= S_RECOV;
                  cnt_q   <= TERM_CYC;
                end
                `SPT_CMD_SWRST: begin
                  state_q <= S_RECOV;
                  cnt_q   <= SWRST_CYC;
                end
                default: state_q <= S_IDLE;
              endcase
            end
          end
          S_ENTER: begin
            // Entry timer runs only once select has risen
            if (!cs_n_q && !cs_rise) begin
              state_q <= S_ENTER;
            end else if (cnt_end) begin
              stay_q <= 32'h0000_0000;
              if (to_ultra_q) begin
                state_q <= S_ULTRA;
                ultra_low_power_sleep_state <= 1'b1;
              end else begin
                state_q <= S_DEEP;
                deep_sleep_state <= 1'b1;
              end
            end else begin
              cnt_q <= cnt_q - 33'h0_0000_0001;
            end
          end
          S_DEEP: begin
            // Only a wake request leaves deep sleep
            if (cmd_valid && sys_cmd == `SPT_CMD_WAKE) begin
              state_q <= S_WAKE;
              cnt_q   <= DEXIT_CYC;
              deep_sleep_state <= 1'b0;
            end
          end
          S_ULTRA: begin
            // Track stay length; wake on select fall
            if (stay_q != 32'hffff_ffff) begin
              stay_q <= stay_q + 32'h0000_0001;
            end
            if (cs_fall) begin
              state_q <= S_WAKE;
              ultra_low_power_sleep_state <= 1'b0;
              cnt_q <= ({1'b0, stay_q} > ULONG_CYC) ? UEXIT_CYC
                                            : UEXIT_LONG_CYC;
            end
          end
          S_WAKE, S_RECOV: begin
            // Recovery countdown before commands are taken
            if (cnt_end) begin
              state_q <= S_IDLE;
            end else begin
              cnt_q <= cnt_q - 33'h0_0000_0001;
            end
          end
          S_OP: begin
            // Busy until the operation timer expires or a terminate request arrives
            if (cmd_valid && sys_cmd == `SPT_CMD_TERM) begin
              state_q <= S_RECOV;
              cnt_q   <= TERM_CYC;
              busy    <= 1'b0;
            end else if (cnt_end) begin
              state_q <= S_IDLE;
              busy    <= 1'b0;
            end else begin
              cnt_q <= cnt_q - 33'h0_0000_0001;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule // spt_seq

// File: dv/spt_seq_sva.sv
// Port checker for the flash power and operation sequencer
`timescale 1ns/1ps
module spt_seq_sva (
  input wire       ref_clk, rstn, por_n, cs_n, sck, cmd_valid, op_valid,
  input wire [2:0] sys_cmd, op_code,
  input wire       so_oe, spi_mode3, cmd_accept, busy, por_done,
  input wire       deep_sleep_state, ultra_low_power_sleep_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  so_hiz_a: assert property (!por_done |-> !so_oe)
    else $error("serial out driven before init done");
  por_block_a: assert property (!por_n |-> !cmd_accept)
    else $error("accepting while power-on reset active");
  mode_pick_a: assert property ($fell(cs_n) |-> ##2 spi_mode3 == sck)
    else $error("mode not taken from clock idle level");
  deep_in_a: assert property (cmd_valid && cmd_accept && sys_cmd == 3'h1
    && cs_n |-> ##[1:7] deep_sleep_state)
    else $error("deep sleep entry late");
  ultra_in_a: assert property (cmd_valid && cmd_accept && sys_cmd == 3'h2
    && cs_n |-> ##[1:7] ultra_low_power_sleep_state)
    else $error("ultra sleep entry late");
  term_ready_a: assert property (busy && cmd_valid && sys_cmd == 3'h3
    |-> ##[1:8] cmd_accept)
    else $error("terminate recovery late");
  swrst_ready_a: assert property (cmd_valid && cmd_accept && sys_cmd == 3'h4
    |=> !cmd_accept ##[1:9] cmd_accept)
    else $error("software reset recovery wrong");
  wrsr_len_a: assert property (op_valid && cmd_accept && op_code == 3'h5
    |=> busy [*8] ##4 busy ##1 !busy)
    else $error("status write busy length wrong");
  deep_wake_a: assert property (deep_sleep_state && cmd_valid &&
    sys_cmd == 3'h5 |-> ##[1:7] cmd_accept)
    else $error("deep sleep wake late");
endmodule // spt_seq_sva
bind spt_seq spt_seq_sva u_sva (.ref_clk(ref_clk), .rstn(rstn), .por_n(por_n),
  .cs_n(cs_n), .sck(sck), .cmd_valid(cmd_valid), .op_valid(op_valid),
  .sys_cmd(sys_cmd), .op_code(op_code), .so_oe(so_oe), .spi_mode3(spi_mode3),
  .cmd_accept(cmd_accept), .busy(busy), .por_done(por_done),
  .deep_sleep_state(deep_sleep_state),
  .ultra_low_power_sleep_state(ultra_low_power_sleep_state));

// File: dv/spt_host_mdl.sv
// Host model: one select frame with the clock held at its idle level
`timescale 1ns/1ps
module spt_host_mdl (
  input  wire ref_clk,
  input  wire go,     // Start one frame
  input  wire mode3,  // Clock idle level for the frame
  output reg  cs_n,   // Select, idle high
  output reg  sck     // Clock stands still outside frames
);
  reg [3:0] cnt_q;    // Frame step counter
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    cnt_q = 4'h0;
  end
  // Idle level set first, select low for five cycles
  always @(posedge ref_clk) begin
    if (go && cnt_q == 4'h0) begin
      sck <= mode3;
      cnt_q <= 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h7) cs_n <= 1'b0;
      if (cnt_q == 4'h2) cs_n <= 1'b1;
    end
  end
endmodule // spt_host_mdl

// File: dv/spt_seq_tb.sv
// Self-checking bench of the flash sequencer
`timescale 1ns/1ps
module spt_seq_tb;
  reg ref_clk, rstn, por_n, hw_reset, go, mode3, cmd_valid, op_valid;
  reg [2:0] sys_cmd, op_code;
  wire cs_n, sck, so_o, so_oe, spi_mode3, cmd_accept, busy, por_done, dss, uss;
  integer err_count, total_checks, cyc, i, n;
  reg [2:0] r_op [0:5];    // Operation kind
  reg [32:0] r_len [0:5];  // Expected busy cycles less one
  reg clk_en, so_data, so_drive; // Freeze and serial out drive
  // Scaled timings so each case runs in a few cycles
  localparam [32:0] T_PWRUP = 33'h14; // Power-up delay
  localparam [32:0] T_DIN   = 33'h4;  // Deep sleep entry
  localparam [32:0] T_UIN   = 33'h4;  // Ultra sleep entry
  localparam [32:0] T_TERM  = 33'h6;  // Terminate recovery
  localparam [32:0] T_SWRST = 33'h8;  // Software reset recovery
  localparam [32:0] T_UEX   = 33'ha;  // Ultra wake after long stay
  localparam [32:0] T_UEXL  = 33'he;  // Ultra wake after short stay
  localparam [32:0] T_ULONG = 33'h1e; // Long stay threshold
  localparam [32:0] T_DEX   = 33'h5;  // Deep sleep wake
  localparam [32:0] T_PAGE  = 33'hc;  // Page program
  localparam [32:0] T_RMW   = 33'h10; // Page write with erase
  localparam [32:0] T_BYTE  = 33'h7;  // Byte program
  localparam [32:0] T_OTP   = 33'h9;  // Security register program
  localparam [32:0] T_WRSR  = 33'hb;  // Status write
  localparam [32:0] T_CHIP  = 33'hd;  // Chip erase
  spt_seq #(.PWRUP_CYC(T_PWRUP), .DEEP_IN_CYC(T_DIN),
    .ULTRA_IN_CYC(T_UIN), .TERM_CYC(T_TERM), .SWRST_CYC(T_SWRST),
    .UEXIT_CYC(T_UEX), .UEXIT_LONG_CYC(T_UEXL), .ULONG_CYC(T_ULONG),
    .DEXIT_CYC(T_DEX), .PAGE_CYC(T_PAGE), .RMW_CYC(T_RMW),
    .BYTE_CYC(T_BYTE), .OTP_CYC(T_OTP), .WRSR_CYC(T_WRSR),
    .CHIP_CYC(T_CHIP)) dut (.ref_clk(ref_clk), .rstn(rstn),
    .clk_en(clk_en), .por_n(por_n), .hw_reset(hw_reset), .cs_n(cs_n),
    .sck(sck), .so_data(so_data), .so_drive(so_drive),
    .sys_cmd(sys_cmd), .cmd_valid(cmd_valid),
    .op_code(op_code), .op_valid(op_valid), .so_o(so_o), .so_oe(so_oe),
    .spi_mode3(spi_mode3), .cmd_accept(cmd_accept), .busy(busy),
    .deep_sleep_state(dss), .ultra_low_power_sleep_state(uss),
    .por_done(por_done));
  spt_host_mdl u_host (.ref_clk(ref_clk), .go(go), .mode3(mode3),
    .cs_n(cs_n), .sck(sck));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      conclude;
    end
  end
  task chk(input logic [32:0] got, input logic [32:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge ref_clk);
      #1;
    end
  endtask
  task frame(input logic m);
    begin
      mode3 <= m;
      go <= 1'b1;
      @(posedge ref_clk);
      go <= 1'b0;
    end
  endtask
  task cmd(input logic [2:0] c);
    begin
      sys_cmd <= c;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
    end
  endtask
  task op(input logic [2:0] c);
    begin
      op_code <= c;
      op_valid <= 1'b1;
      @(posedge ref_clk);
      op_valid <= 1'b0;
    end
  endtask
  // Cycles until commands are taken again
  task wait_acc;
    begin
      n = 0;
      #1;
      while (cmd_accept !== 1'b1 && n < 4000) begin
        tick(1);
        n = n + 1;
      end
    end
  endtask
  initial begin
    {rstn, por_n, hw_reset, go, mode3, cmd_valid, op_valid} = 7'h00;
    {sys_cmd, op_code} = 6'h00;
    {clk_en, so_data, so_drive} = 3'h4;
    {err_count, total_checks, cyc} = 0;
    r_op[0] = 3'h1; r_op[1] = 3'h2; r_op[2] = 3'h3;
    r_op[3] = 3'h4; r_op[4] = 3'h5; r_op[5] = 3'h6;
    r_len[0] = T_PAGE; r_len[1] = T_RMW; r_len[2] = T_BYTE;
    r_len[3] = T_OTP; r_len[4] = T_WRSR; r_len[5] = T_CHIP;
    tick(16);
    chk(so_oe, 0);
    @(posedge ref_clk) rstn <= 1'b1;
    tick(30);
    op(3'h1);
    tick(1);
    chk({busy, por_done, cmd_accept}, 0);
    @(posedge ref_clk) por_n <= 1'b1;
    tick(10);
    @(posedge ref_clk) hw_reset <= 1'b1;
    @(posedge ref_clk) hw_reset <= 1'b0;
    tick(15);
    chk(por_done, 0);
    tick(20);
    chk({por_done, cmd_accept, so_oe}, 3'h4);
    for (i = 0; i < 3; i = i + 1) begin
      frame(i[0]);
      tick(10);
      chk(spi_mode3, i[0]);
    end
    // Serial out driven only while selected and ready
    so_data <= 1'b1;
    so_drive <= 1'b1;
    frame(1'b0);
    tick(4);
    chk({so_oe, so_o}, 2'h3);
    tick(6);
    chk(so_oe, 0);
    so_drive <= 1'b0;
    $display("power-up test done");
    for (i = 0; i < 6; i = i + 1) begin
      wait_acc;
      op(r_op[i]);
      wait_acc;
      chk(n, r_len[i] + 1);
    end
    $display("operation table done");
    cmd(3'h1);
    tick(6);
    chk(dss, 1);
    cmd(3'h5);
    wait_acc;
    chk(n, T_DEX + 1);
    cmd(3'h2);
    tick(6);
    chk(uss, 1);
    frame(1'b0);
    wait_acc;
    // Host drops select two edges after the frame call returns
    chk(n, T_UEXL + 4);
    cmd(3'h2);
    tick(40);
    frame(1'b0);
    wait_acc;
    chk(n, T_UEX + 4);
    op(3'h2);
    tick(3);
    cmd(3'h3);
    wait_acc;
    chk(n, T_TERM + 1);
    chk(busy, 0);
    cmd(3'h4);
    frame(1'b1);
    wait_acc;
    // The frame call used up one edge of the recovery
    chk(n, T_SWRST);
    // Frozen clock enable stretches a byte program
    op(3'h3);
    clk_en <= 1'b0;
    tick(20);
    chk(busy, 1);
    clk_en <= 1'b1;
    wait_acc;
    chk(n, T_BYTE + 1);
    // Hardware reset after init must not restart it
    @(posedge ref_clk) hw_reset <= 1'b1;
    @(posedge ref_clk) hw_reset <= 1'b0;
    tick(2);
    chk({por_done, cmd_accept}, 2'h3);
    $display("sleep and reset tests done");
    conclude;
  end
endmodule // spt_seq_tb
